// [hw/ddb_pkg.sv]
// Purpose: Shared constants for the dual converter board link
// Assumes: One 20 MHz clock shared by host and board logic
// Notes: Bus command codes and address layout live here
package ddb_pkg;
   // Widths
   localparam int DATA_W = 12;
   localparam int ADDR_W = 12;
   localparam int LOG_W = 6;
   localparam int CNT_W = 4;
   // Clock rate and serial bit time
   localparam int CLK_HZ = 20000000;
   localparam int BIT_NS = 200;
   localparam int BIT_CYC = (BIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
   // Link command codes
   localparam logic [2:0] CMD_NOP = 3'h0;
   localparam logic [2:0] CMD_SHIFT1 = 3'h1;
   localparam logic [2:0] CMD_SHIFT2 = 3'h2;
   localparam logic [2:0] CMD_LATCH1 = 3'h3;
   localparam logic [2:0] CMD_LATCH2 = 3'h4;
   localparam logic [2:0] CMD_INIT = 3'h5;
   // Fixed address fields, zero code and full word count
   localparam logic [2:0] ADDR_FIX_MID = 3'h1;
   localparam logic [2:0] ADDR_FIX_LO = 3'h0;
   localparam logic [DATA_W-1:0] ZERO_CODE = 12'h000;
   localparam logic [CNT_W-1:0] FULL_CNT = 4'hc;
   // Host user operations
   localparam logic [1:0] OP_SEL = 2'h0;
   localparam logic [1:0] OP_LOAD = 2'h1;
   localparam logic [1:0] OP_LATCH = 2'h2;
   localparam logic [1:0] OP_INIT = 2'h3;

   // Physical address from logical number: code, x, 001, y, 000, z
   function automatic logic [ADDR_W-1:0] phys_addr(input logic [LOG_W-1:0] lg);
      phys_addr = {lg[5:3], lg[0], ADDR_FIX_MID, lg[1], ADDR_FIX_LO, lg[2]};
   endfunction

   // First and third nibbles swap places on the bus
   function automatic logic [ADDR_W-1:0] nib_swap(input logic [ADDR_W-1:0] a);
      nib_swap = {a[3:0], a[7:4], a[11:8]};
   endfunction
endpackage

// [hw/ddb_if.sv]
// Purpose: Link between host controller and converter board
// Assumes: All signals synchronous to the shared clock
// Notes: Host drives strobes; board returns its select level
`timescale 1ns/1ps
`default_nettype none
interface ddb_if;
   logic addr_stb;
   logic [11:0] addr;
   logic cmd_stb;
   logic [2:0] cmd;
   logic sdat;
   logic board_sel;

   // Host end
   modport host (
      output addr_stb, addr, cmd_stb, cmd, sdat,
      input board_sel
   );

   // Board end
   modport board (
      input addr_stb, addr, cmd_stb, cmd, sdat,
      output board_sel
   );
endinterface
`default_nettype wire

// [hw/ddb_board.sv]
// Purpose: Digital logic of the two channel converter board
// Assumes: Host keeps to the link protocol; inputs synchronous
// Notes: Converter output registers drive the analog stage
//    Holding registers fill serially; only a latch moves them on
//    Select is held between address strobes, lamp follows it
//    Init clears the output registers, not the holding registers
`timescale 1ns/1ps
`default_nettype none
module ddb_board #(
   parameter int DATA_W = ddb_pkg::DATA_W
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   ddb_if.board lnk,
   input wire logic [2:0] logic_code_in,
   input wire logic [2:0] jumper_fitted_in,
   output logic select_indicator_lamp_out,
   output logic [DATA_W-1:0] first_converter_channel_out,
   output logic [DATA_W-1:0] second_converter_channel_out,
   output logic [1:0] conv_update_out,
   output logic [1:0] hold_full_out
);

   // Whole board state
   typedef struct packed {
      logic sel;
      logic [1:0][DATA_W-1:0] hold;
      logic [1:0][DATA_W-1:0] outr;
      logic [1:0][ddb_pkg::CNT_W-1:0] cnt;
      logic [1:0] full;
      logic [1:0] upd;
   } ddb_board_st_t;

   // State and its next value
   ddb_board_st_t st_ff;
   ddb_board_st_t nxt_st;

   // Address decode
   logic [2:0] jmp_bits;
   logic jmp_x;
   logic jmp_y;
   logic jmp_z;
   logic [ddb_pkg::LOG_W-1:0] log_num;
   logic [ddb_pkg::ADDR_W-1:0] own_addr;
   logic [ddb_pkg::ADDR_W-1:0] bus_phys;
   logic addr_hit;

   // Command decode
   logic cmd_ok;
   logic [1:0] shift_ch;
   logic [1:0] latch_ch;
   logic do_init;

   // Per channel helpers
   logic [1:0][DATA_W-1:0] hold_shifted;
   logic [1:0][ddb_pkg::CNT_W-1:0] cnt_inc;
   logic [1:0] cnt_last;
   logic [1:0] cnt_top;

   // Jumper bits: fitted pair gives zero, open pair one
   assign jmp_bits = ~jumper_fitted_in;

   // First, second and third jumper pairs give x, y and z
   assign jmp_x = jmp_bits[0];
   assign jmp_y = jmp_bits[1];
   assign jmp_z = jmp_bits[2];

   // Logical number laid out as code bits then z y x
   assign log_num = {logic_code_in, jmp_z, jmp_y, jmp_x};

   // Physical address this board answers to
   // Layout: code bits, x, fixed 001, y, fixed 000, z
   assign own_addr = ddb_pkg::phys_addr(log_num);

   // Undo the nibble interchange done by the host
   assign bus_phys = ddb_pkg::nib_swap(lnk.addr);

   // Address compare
   assign addr_hit = (bus_phys == own_addr);

   // Commands only act while selected
   assign cmd_ok = lnk.cmd_stb & st_ff.sel;

   // Link as seen from the board
   //    address strobe: select follows the address match
   //    shift 1 and shift 2: one serial bit into a holding register
   //    latch 1 and latch 2: holding register to output register
   //    init: both output registers to zero code
   //    other codes, or any command while unselected: no effect
   //    holding registers keep their value across latch and init
   //    bit counters stop at a full word; extra bits push out the oldest
   //    no handshake: every strobe is taken at the edge that sees it

   // Command decode per channel
   always_comb begin
      shift_ch = 2'b00;
      latch_ch = 2'b00;
      do_init = 1'b0;
      if (cmd_ok) begin
         case (lnk.cmd)
            ddb_pkg::CMD_SHIFT1: begin
               shift_ch = 2'b01;
            end
            ddb_pkg::CMD_SHIFT2: begin
               shift_ch = 2'b10;
            end
            ddb_pkg::CMD_LATCH1: begin
               latch_ch = 2'b01;
            end
            ddb_pkg::CMD_LATCH2: begin
               latch_ch = 2'b10;
            end
            ddb_pkg::CMD_INIT: begin
               do_init = 1'b1;
            end
            default: begin
               do_init = 1'b0;
            end
         endcase
      end
   end

   // Per channel shift helpers, one copy per converter
   for (genvar g = 0; g < 2; g++) begin : g_chan
      // Holding value with the new bit in the LSB, MSB first
      assign hold_shifted[g] = {st_ff.hold[g][DATA_W-2:0], lnk.sdat};
      // Bit count one further along
      assign cnt_inc[g] = st_ff.cnt[g] + 4'h1;
      // Counter sits on the last bit of a word
      assign cnt_last[g] = (st_ff.cnt[g] == ddb_pkg::FULL_CNT - 4'h1);
      // Counter has stopped at a whole word
      assign cnt_top[g] = (st_ff.cnt[g] == ddb_pkg::FULL_CNT);
   end

   // Next state
   always_comb begin
      nxt_st = st_ff;
      // Update pulses last a single cycle
      nxt_st.upd = 2'b00;

      // Select follows every address placed on the bus
      if (lnk.addr_stb) begin
         nxt_st.sel = addr_hit;
      end

      // Serial shift into holding register, MSB first
      for (int ch = 0; ch < 2; ch++) begin
         if (shift_ch[ch]) begin
            nxt_st.hold[ch] = hold_shifted[ch];
            if (!cnt_top[ch]) begin
               nxt_st.cnt[ch] = cnt_inc[ch];
            end
            if (cnt_last[ch]) begin
               nxt_st.full[ch] = 1'b1;
            end
         end
      end

      // Latch moves holding value to output register
      for (int ch = 0; ch < 2; ch++) begin
         if (latch_ch[ch]) begin
            nxt_st.outr[ch] = st_ff.hold[ch];
            nxt_st.upd[ch] = 1'b1;
            nxt_st.cnt[ch] = '0;
            nxt_st.full[ch] = 1'b0;
         end
      end

      // Init drives both outputs to zero code
      if (do_init) begin
         nxt_st.outr[0] = ddb_pkg::ZERO_CODE;
         nxt_st.outr[1] = ddb_pkg::ZERO_CODE;
         nxt_st.upd = 2'b11;
      end
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Select level to lamp and back to the host
   assign select_indicator_lamp_out = st_ff.sel;
   assign lnk.board_sel = st_ff.sel;

   // Converter output registers
   assign first_converter_channel_out = st_ff.outr[0];
   assign second_converter_channel_out = st_ff.outr[1];

   // Per channel status straight from state flops
   assign conv_update_out = st_ff.upd;
   assign hold_full_out = st_ff.full;

endmodule
`default_nettype wire

// [hw/ddb_host.sv]
// Purpose: Host controller end of the converter board link
// Assumes: User waits for ready before each operation
// Notes: Serial bits paced by a divider enable
`timescale 1ns/1ps
`default_nettype none
module ddb_host #(
   parameter int DATA_W = ddb_pkg::DATA_W,
   parameter int BIT_CYC = ddb_pkg::BIT_CYC
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   ddb_if.host lnk,
   input wire logic op_valid_in,
   input wire logic [1:0] op_in,
   input wire logic op_chan_in,
   input wire logic [ddb_pkg::LOG_W-1:0] log_addr_in,
   input wire logic [DATA_W-1:0] value_in,
   output logic ready_out,
   output logic done_out,
   output logic refused_out,
   output logic board_sel_out
);

   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_SHIFT = 3'b010,
      S_DONE = 3'b100
   } ddb_host_fsm_t;

   // Whole host state
   typedef struct packed {
      ddb_host_fsm_t fsm;
      logic addressed;
      logic addr_stb;
      logic [ddb_pkg::ADDR_W-1:0] addr;
      logic cmd_stb;
      logic [2:0] cmd;
      logic sdat;
      logic [DATA_W-1:0] shreg;
      logic [ddb_pkg::CNT_W-1:0] cnt;
      logic [7:0] div;
      logic chan;
      logic ready;
      logic done;
      logic refused;
      logic bsel;
   } ddb_host_st_t;

   ddb_host_st_t st_ff;
   ddb_host_st_t nxt_st;
   logic bit_en;

   // Bit rate enable from divider
   assign bit_en = (st_ff.div == 8'(BIT_CYC - 1));

   always_comb begin
      nxt_st = st_ff;
      nxt_st.addr_stb = 1'b0;
      nxt_st.cmd_stb = 1'b0;
      nxt_st.done = 1'b0;
      nxt_st.refused = 1'b0;
      nxt_st.bsel = lnk.board_sel;
      nxt_st.div = bit_en ? 8'h00 : st_ff.div + 8'h01;
      case (st_ff.fsm)
         S_IDLE: begin
            if (op_valid_in) begin
               if (op_in == ddb_pkg::OP_SEL) begin
                  // Address goes out nibble interchanged
                  nxt_st.addr = ddb_pkg::nib_swap(ddb_pkg::phys_addr(log_addr_in));
                  nxt_st.addr_stb = 1'b1;
                  nxt_st.addressed = 1'b1;
                  nxt_st.fsm = S_DONE;
                  nxt_st.ready = 1'b0;
               end else if (!st_ff.addressed) begin
                  nxt_st.refused = 1'b1;
               end else if (op_in == ddb_pkg::OP_LOAD) begin
                  nxt_st.shreg = value_in;
                  nxt_st.chan = op_chan_in;
                  nxt_st.cnt = '0;
                  nxt_st.fsm = S_SHIFT;
                  nxt_st.ready = 1'b0;
               end else begin
                  // Latch of chosen channel or init
                  nxt_st.cmd_stb = 1'b1;
                  if (op_in == ddb_pkg::OP_INIT) begin
                     nxt_st.cmd = ddb_pkg::CMD_INIT;
                  end else begin
                     nxt_st.cmd = op_chan_in ? ddb_pkg::CMD_LATCH2 : ddb_pkg::CMD_LATCH1;
                  end
                  nxt_st.fsm = S_DONE;
                  nxt_st.ready = 1'b0;
               end
            end
         end
         S_SHIFT: begin
            // One bit per enable, MSB first
            if (bit_en) begin
               nxt_st.cmd_stb = 1'b1;
               nxt_st.cmd = st_ff.chan ? ddb_pkg::CMD_SHIFT2 : ddb_pkg::CMD_SHIFT1;
               nxt_st.sdat = st_ff.shreg[DATA_W-1];
               nxt_st.shreg = {st_ff.shreg[DATA_W-2:0], 1'b0};
               nxt_st.cnt = st_ff.cnt + 4'h1;
               if (st_ff.cnt == ddb_pkg::FULL_CNT - 4'h1) begin
                  nxt_st.fsm = S_DONE;
               end
            end
         end
         S_DONE: begin
            nxt_st.done = 1'b1;
            nxt_st.ready = 1'b1;
            nxt_st.fsm = S_IDLE;
         end
         default: begin
            nxt_st.fsm = S_IDLE;
            nxt_st.ready = 1'b1;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st_ff <= '{fsm: S_IDLE, ready: 1'b1, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Link and user outputs from flops
   assign lnk.addr_stb = st_ff.addr_stb;
   assign lnk.addr = st_ff.addr;
   assign lnk.cmd_stb = st_ff.cmd_stb;
   assign lnk.cmd = st_ff.cmd;
   assign lnk.sdat = st_ff.sdat;
   assign ready_out = st_ff.ready;
   assign done_out = st_ff.done;
   assign refused_out = st_ff.refused;
   assign board_sel_out = st_ff.bsel;

endmodule
`default_nettype wire

// [testbench/ddb_chk.sv]
// Purpose: Link checks between host and converter board
// Assumes: One clock, synchronous active high reset
// Notes: Shadow copies of both holding registers
`timescale 1ns/1ps
`default_nettype none
module ddb_chk (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic addr_stb,
   input wire logic [11:0] addr,
   input wire logic cmd_stb,
   input wire logic [2:0] cmd,
   input wire logic sdat,
   input wire logic board_sel,
   input wire logic [2:0] logic_code_in,
   input wire logic [2:0] jumper_fitted_in,
   input wire logic select_indicator_lamp_out,
   input wire logic [11:0] first_converter_channel_out,
   input wire logic [11:0] second_converter_channel_out,
   input wire logic [1:0] conv_update_out
);
   typedef struct packed {
      logic [11:0] h0;
      logic [11:0] h1;
   } ddb_shadow_t;
   ddb_shadow_t st_ff;
   ddb_shadow_t nxt_st;
   logic [11:0] pa;
   logic [11:0] ba;
   logic go;
   // Own bus address: open pair reads one, outer nibbles swapped
   assign pa = {logic_code_in, ~jumper_fitted_in[0], 3'h1, ~jumper_fitted_in[1], 3'h0,
      ~jumper_fitted_in[2]};
   assign ba = {pa[3:0], pa[7:4], pa[11:8]};
   assign go = cmd_stb && board_sel;
   // Shift shadows while selected
   always_comb begin
      nxt_st = st_ff;
      if (go && cmd == ddb_pkg::CMD_SHIFT1) begin
         nxt_st.h0 = {st_ff.h0[10:0], sdat};
      end
      if (go && cmd == ddb_pkg::CMD_SHIFT2) begin
         nxt_st.h1 = {st_ff.h1[10:0], sdat};
      end
   end
   always_ff @(posedge sys_clk_in) begin
      st_ff <= rst_in ? '0 : nxt_st;
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   sel_match_a: assert property (addr_stb |=>
      board_sel == ($past(addr) == $past(ba)))
      else $error("select does not follow address match");
   sel_keep_a: assert property (!addr_stb |=> board_sel == $past(board_sel))
      else $error("select changed without address");
   lamp_sel_a: assert property (select_indicator_lamp_out == board_sel)
      else $error("lamp differs from select");
   latch_one_a: assert property (go && cmd == ddb_pkg::CMD_LATCH1 |=>
      first_converter_channel_out == $past(st_ff.h0) && conv_update_out == 2'h1)
      else $error("first channel latch wrong");
   latch_two_a: assert property (go && cmd == ddb_pkg::CMD_LATCH2 |=>
      second_converter_channel_out == $past(st_ff.h1) && conv_update_out == 2'h2)
      else $error("second channel latch wrong");
   no_update_a: assert property (cmd_stb && (!board_sel || cmd == ddb_pkg::CMD_SHIFT1 ||
      cmd == ddb_pkg::CMD_SHIFT2) |=> conv_update_out == 2'h0 &&
      $stable(first_converter_channel_out) && $stable(second_converter_channel_out))
      else $error("output moved without latch");
   init_zero_a: assert property (go && cmd == ddb_pkg::CMD_INIT |=>
      first_converter_channel_out == 12'h000 && second_converter_channel_out == 12'h000 &&
      conv_update_out == 2'h3)
      else $error("init did not zero outputs");
   strobe_excl_a: assert property (!(addr_stb && cmd_stb))
      else $error("address and command strobes together");
endmodule
`default_nettype wire

// [testbench/dual_dac_bus_board_logic_tb.sv]
// Purpose: End to end test of host and converter board
// Assumes: Host bit divider shortened to two cycles
// Notes: Board code and jumpers swept through all values
`timescale 1ns/1ps
`default_nettype none
module dual_dac_bus_board_logic_tb;
   logic sys_clk_in;
   logic rst_in;
   logic vld;
   logic [1:0] k;
   logic ch;
   logic [5:0] la;
   logic [11:0] v;
   logic [2:0] code;
   logic [2:0] jf;
   logic rdy, done, refd, bsel, lamp, sref;
   logic [11:0] oa, ob;
   logic [1:0] upd, full;
   logic [11:0] ex [2];
   logic [11:0] tv [4] = '{12'hfff, 12'h001, 12'ha5c, 12'h800};
   int mismatches = 0;
   int num_checks = 0;
   ddb_if lnk ();
   ddb_host #(.BIT_CYC(2)) ddb_host_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .lnk(lnk.host), .op_valid_in(vld), .op_in(k), .op_chan_in(ch), .log_addr_in(la),
      .value_in(v), .ready_out(rdy), .done_out(done), .refused_out(refd), .board_sel_out(bsel));
   ddb_board ddb_board_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .lnk(lnk.board),
      .logic_code_in(code), .jumper_fitted_in(jf), .select_indicator_lamp_out(lamp),
      .first_converter_channel_out(oa), .second_converter_channel_out(ob),
      .conv_update_out(upd), .hold_full_out(full));
   ddb_chk ddb_chk_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_stb(lnk.addr_stb),
      .addr(lnk.addr), .cmd_stb(lnk.cmd_stb), .cmd(lnk.cmd), .sdat(lnk.sdat),
      .board_sel(lnk.board_sel), .logic_code_in(code), .jumper_fitted_in(jf),
      .select_indicator_lamp_out(lamp), .first_converter_channel_out(oa),
      .second_converter_channel_out(ob), .conv_update_out(upd));
   // Clock, 50 ns period
   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One user operation, then wait for done or refusal
   task automatic op(input logic [1:0] kk, input logic c, input logic [11:0] d,
      input logic [5:0] a);
      int n;
      @(negedge sys_clk_in);
      vld = 1'b1;
      k = kk;
      ch = c;
      v = d;
      la = a;
      @(negedge sys_clk_in);
      vld = 1'b0;
      n = 0;
      while (done !== 1'b1 && refd !== 1'b1 && n < 100) begin
         @(negedge sys_clk_in);
         n++;
      end
      sref = refd;
      if (n == 100) begin
         mismatches++;
         $display("MISMATCH %0t operation hung", $time);
      end
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      mismatches++;
      test_done;
   end
   // Main sequence
   initial begin
      vld = 1'b0;
      k = 2'h0;
      ch = 1'b0;
      la = 6'h00;
      v = 12'h000;
      code = 3'h5;
      jf = 3'h0;
      sref = 1'b0;
      rst_in = 1'b1;
      repeat (10) @(negedge sys_clk_in);
      rst_in = 1'b0;
      chk(lamp, 12'h000);
      op(ddb_pkg::OP_LATCH, 1'b0, 12'h000, 6'h00);
      chk(sref, 12'h001);
      chk(rdy, 12'h001);
      // Sweep code and jumpers: wrong number, then right one
      for (int j = 0; j < 8; j++) begin
         code = j[2:0] ^ 3'h5;
         jf = j[2:0] ^ 3'h3;
         op(ddb_pkg::OP_SEL, 1'b0, 12'h000, {code, ~jf[2], ~jf[1], ~jf[0]} ^ (6'h01 << (j % 6)));
         chk(lamp, 12'h000);
         op(ddb_pkg::OP_SEL, 1'b0, 12'h000, {code, ~jf[2], ~jf[1], ~jf[0]});
         chk(lamp, 12'h001);
         chk(lnk.addr, {3'h0, ~jf[2], 3'h1, ~jf[1], code, ~jf[0]});
      end
      @(negedge sys_clk_in);
      chk(bsel, 12'h001);
      ex[0] = 12'h000;
      ex[1] = 12'h000;
      // Load, check output held, then latch
      for (int i = 0; i < 4; i++) begin
         op(ddb_pkg::OP_LOAD, i[0], tv[i], 6'h00);
         chk(full[i[0]], 12'h001);
         chk(i[0] ? ob : oa, ex[i[0]]);
         op(ddb_pkg::OP_LATCH, i[0], 12'h000, 6'h00);
         ex[i[0]] = tv[i];
         chk(oa, ex[0]);
         chk(ob, ex[1]);
      end
      // Two loads, one latch, no reselect
      op(ddb_pkg::OP_LOAD, 1'b0, 12'h123, 6'h00);
      op(ddb_pkg::OP_LOAD, 1'b0, 12'h456, 6'h00);
      op(ddb_pkg::OP_LATCH, 1'b0, 12'h000, 6'h00);
      chk(oa, 12'h456);
      op(ddb_pkg::OP_INIT, 1'b0, 12'h000, 6'h00);
      chk(oa, 12'h000);
      chk(ob, 12'h000);
      // Deselected board ignores load and latch
      op(ddb_pkg::OP_SEL, 1'b0, 12'h000, 6'h00);
      chk(lamp, 12'h000);
      op(ddb_pkg::OP_LOAD, 1'b0, 12'h777, 6'h00);
      op(ddb_pkg::OP_LATCH, 1'b0, 12'h000, 6'h00);
      chk(oa, 12'h000);
      chk(full[0], 12'h000);
      test_done;
   end
endmodule
`default_nettype wire
